// ---- inc/meas_cfg_pkg.sv ----
// shared constants and types for the measurement configuration block
package meas_cfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PROX_REC = 8'h0a;
  localparam logic [7:0] IDX_PROX_GAIN = 8'h0b;
  localparam logic [7:0] IDX_PROX_MISC = 8'h0c;
  localparam logic [7:0] IDX_IR_SEL = 8'h0e;
  localparam logic [7:0] IDX_AUX_SEL = 8'h0f;
  localparam logic [7:0] IDX_VIS_REC = 8'h10;
  localparam logic [7:0] IDX_VIS_GAIN = 8'h11;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;

  // reset values
  localparam logic [7:0] RST_PROX_REC = 8'h70;
  localparam logic [7:0] RST_PROX_GAIN = 8'h00;
  localparam logic [7:0] RST_PROX_MISC = 8'h04;
  localparam logic [7:0] RST_IR_SEL = 8'h00;
  localparam logic [7:0] RST_AUX_SEL = 8'h65;
  localparam logic [7:0] RST_VIS_REC = 8'h70;
  localparam logic [7:0] RST_VIS_GAIN = 8'h00;

  // field positions and writable masks
  localparam int GAIN_LSB = 0;
  localparam int REC_LSB = 4;
  localparam int RANGE_BIT = 5;
  localparam int MODE_BIT = 2;
  localparam logic [7:0] MASK_GAIN = 8'h07;
  localparam logic [7:0] MASK_REC = 8'h70;
  localparam logic [7:0] MASK_MISC = 8'h24;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_KIND_LSB = 1;
  localparam int CTRL_EARLY_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // input codes of the mux selections
  localparam logic [7:0] IR_SMALL_CODE = 8'h00;
  localparam logic [7:0] IR_LARGE_CODE = 8'h03;
  localparam logic [7:0] AUX_TEMP_CODE = 8'h65;
  localparam logic [7:0] AUX_VDD_CODE = 8'h75;

  // timing: adc clock base period and system clock period
  localparam int unsigned ADC_CLK_NS = 50;
  localparam int unsigned CLK_NS = 20;
  localparam logic [9:0] INTEG_BASE_ADC_CLKS = 10'd16;
  localparam logic [9:0] LED_BASE_ADC_CLKS = 10'd8;
  localparam logic [9:0] REC_CLKS [8] = '{
    10'd1, 10'd7, 10'd15, 10'd31, 10'd63, 10'd127, 10'd255, 10'd511};

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    KIND_PROX, KIND_VIS, KIND_IR, KIND_AUX
  } meas_kind_t;

  typedef struct packed {
    meas_kind_t kind;
    logic [7:0] input_code;
    logic recovering;
    logic integrating;
    logic led_on;
    logic high_range;
    logic raw_mode;
    logic done;
  } meas_ctrl_t;

endpackage : meas_cfg_pkg

// ---- rtl/meas_cfg.sv ----
// axi4-lite configuration registers and measurement sequencer
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Operation
// [RULE1] prox gain scales led pulse and integration
// [RULE2] host keeps prox gain at five or below
// [RULE3] gain applied unclamped, no safety check
// [RULE4] misc bit5 selects high signal range
// [RULE5] misc bit2: 0 raw, 1 normal; reset 1
// [RULE6] ir select 0x00 small, 0x03 large
// [RULE7] aux 0x65 temperature, 0x75 supply; reset temperature
// [RULE8] visible recovery code gives 1..511 adc clocks
// [RULE9] adc clock 50 ns times two^visible gain
// [RULE10] host sets recovery to gain complement
// [RULE11] early silicon: visible settings govern ambient ir
// [RULE12] prox recovery scaled by two^prox gain
// [RULE13] visible gain scales visible integration time
// [RULE14] reserved bits read zero, ignored; status bits 3:2 read state_reg instead
module meas_cfg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output meas_cfg_pkg::meas_ctrl_t meas
);
  import meas_cfg_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RECOVER, ST_INTEGRATE} seq_state_t;

  logic [7:0] prox_rec_reg;
  logic [7:0] prox_gain_reg;
  logic [7:0] prox_misc_reg;
  logic [7:0] ir_sel_reg;
  logic [7:0] aux_sel_reg;
  logic [7:0] vis_rec_reg;
  logic [7:0] vis_gain_reg;
  logic early_reg;
  logic done_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_idx_reg;
  logic aw_ok_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic do_write;
  logic start_pulse;
  logic done_clear;
  meas_kind_t start_kind;
  seq_state_t state_reg;
  logic [23:0] cnt_reg;
  logic [23:0] rec_cyc_reg;
  logic [23:0] int_cyc_reg;
  logic [23:0] led_cyc_reg;
  logic [2:0] sel_gain;
  logic [2:0] sel_rec;
  logic [7:0] sel_code;
  logic use_led;
  logic [7:0] rd_byte;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic aligned_ok(input logic [31:0] addr);
    logic ok;
    ok = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h0);
    return ok;
  endfunction : aligned_ok

  function automatic logic mapped(input logic [7:0] idx);
    logic hit;
    case (idx)
      IDX_PROX_REC, IDX_PROX_GAIN, IDX_PROX_MISC, IDX_IR_SEL,
      IDX_AUX_SEL, IDX_VIS_REC, IDX_VIS_GAIN, IDX_CTRL,
      IDX_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : mapped

  // adc clocks times two^gain, turned into system cycles, rounded up
  function automatic logic [23:0] to_cycles(input logic [9:0] adc_clks,
                                            input logic [2:0] gain);
    logic [31:0] ns;
    ns = ({22'h0, adc_clks} << gain) * ADC_CLK_NS;
    return 24'((ns + CLK_NS - 32'd1) / CLK_NS);
  endfunction : to_cycles

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      aw_ok_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[9:2];
      aw_ok_reg <= aligned_ok(s_axi_awaddr) && mapped(s_axi_awaddr[9:2]);
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok_reg ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  // [RULE14] reserved bits masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prox_rec_reg <= RST_PROX_REC;
      prox_gain_reg <= RST_PROX_GAIN;
      prox_misc_reg <= RST_PROX_MISC;
      ir_sel_reg <= RST_IR_SEL;
      aux_sel_reg <= RST_AUX_SEL;
      vis_rec_reg <= RST_VIS_REC;
      vis_gain_reg <= RST_VIS_GAIN;
      early_reg <= 1'b0;
    end else if (do_write && aw_ok_reg && wstrb0_reg) begin
      case (aw_idx_reg)
        IDX_PROX_REC: prox_rec_reg <= wdata_reg & MASK_REC;
        // [RULE3] stored unclamped, only the bits above MASK_GAIN dropped
        IDX_PROX_GAIN: prox_gain_reg <= wdata_reg & MASK_GAIN;
        IDX_PROX_MISC: prox_misc_reg <= wdata_reg & MASK_MISC;
        IDX_IR_SEL: ir_sel_reg <= wdata_reg;
        IDX_AUX_SEL: aux_sel_reg <= wdata_reg;
        IDX_VIS_REC: vis_rec_reg <= wdata_reg & MASK_REC;
        IDX_VIS_GAIN: vis_gain_reg <= wdata_reg & MASK_GAIN;
        IDX_CTRL: early_reg <= wdata_reg[CTRL_EARLY_BIT];
        default: ;
      endcase
    end
  end

  assign start_pulse = do_write && aw_ok_reg && wstrb0_reg &&
                       (aw_idx_reg == IDX_CTRL) &&
                       wdata_reg[CTRL_START_BIT];
  assign start_kind = meas_kind_t'(wdata_reg[CTRL_KIND_LSB +: 2]);
  assign done_clear = do_write && aw_ok_reg && wstrb0_reg &&
                      (aw_idx_reg == IDX_STATUS) &&
                      wdata_reg[STAT_DONE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // read channel

  always_comb begin
    rd_byte = 8'h00;
    case (s_axi_araddr[9:2])
      IDX_PROX_REC: rd_byte = prox_rec_reg;
      IDX_PROX_GAIN: rd_byte = prox_gain_reg;
      IDX_PROX_MISC: rd_byte = prox_misc_reg;
      IDX_IR_SEL: rd_byte = ir_sel_reg;
      IDX_AUX_SEL: rd_byte = aux_sel_reg;
      IDX_VIS_REC: rd_byte = vis_rec_reg;
      IDX_VIS_GAIN: rd_byte = vis_gain_reg;
      IDX_CTRL: rd_byte = {3'b000, early_reg, 1'b0, meas.kind, 1'b0};
      IDX_STATUS: rd_byte = {4'h0, state_reg, done_reg,
                             state_reg != ST_IDLE};
      default: rd_byte = 8'h00;
    endcase
  end

  assign rd_ok = aligned_ok(s_axi_araddr) && mapped(s_axi_araddr[9:2]);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-kind gain, recovery code and input selection

  always_comb begin
    sel_gain = 3'd0;
    sel_rec = 3'd0;
    sel_code = 8'h00;
    use_led = 1'b0;
    case (start_kind)
      KIND_PROX: begin
        // [RULE1] [RULE12] prox gain and recovery
        sel_gain = prox_gain_reg[GAIN_LSB +: 3];
        sel_rec = prox_rec_reg[REC_LSB +: 3];
        // [RULE5] led only in normal mode
        use_led = prox_misc_reg[MODE_BIT];
      end
      KIND_VIS: begin
        // [RULE8] [RULE13] visible recovery and gain
        sel_gain = vis_gain_reg[GAIN_LSB +: 3];
        sel_rec = vis_rec_reg[REC_LSB +: 3];
      end
      KIND_IR: begin
        // [RULE11] early parts borrow visible settings
        sel_gain = early_reg ? vis_gain_reg[GAIN_LSB +: 3] : 3'd0;
        sel_rec = early_reg ? vis_rec_reg[REC_LSB +: 3] : 3'd0;
        // [RULE6] ir photodiode select
        sel_code = ir_sel_reg;
      end
      KIND_AUX: begin
        // [RULE7] temperature or supply code
        sel_code = aux_sel_reg;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer; settings snapshot at start so later writes wait

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 24'h00_0000;
      rec_cyc_reg <= 24'h00_0001;
      int_cyc_reg <= 24'h00_0001;
      led_cyc_reg <= 24'h00_0000;
      meas <= '0;
    end else begin
      meas.done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_pulse) begin
            state_reg <= ST_RECOVER;
            cnt_reg <= 24'h00_0000;
            // [RULE9] recovery clock scaled by two^gain
            rec_cyc_reg <= to_cycles(REC_CLKS[sel_rec], sel_gain);
            int_cyc_reg <= to_cycles(INTEG_BASE_ADC_CLKS, sel_gain);
            // [RULE1] led pulse scaled too
            led_cyc_reg <= use_led ?
                           to_cycles(LED_BASE_ADC_CLKS, sel_gain) :
                           24'h00_0000;
            meas.kind <= start_kind;
            meas.input_code <= sel_code;
            meas.recovering <= 1'b1;
            // [RULE4] range flag for prox conversions
            meas.high_range <= (start_kind == KIND_PROX) &&
                               prox_misc_reg[RANGE_BIT];
            // [RULE5] raw adc when mode bit clear
            meas.raw_mode <= (start_kind == KIND_PROX) &&
                             !prox_misc_reg[MODE_BIT];
          end
        end
        ST_RECOVER: begin
          if (cnt_reg == rec_cyc_reg - 24'd1) begin
            state_reg <= ST_INTEGRATE;
            cnt_reg <= 24'h00_0000;
            meas.recovering <= 1'b0;
            meas.integrating <= 1'b1;
            meas.led_on <= led_cyc_reg != 24'h00_0000;
          end else begin
            cnt_reg <= cnt_reg + 24'd1;
          end
        end
        ST_INTEGRATE: begin
          if (cnt_reg == led_cyc_reg - 24'd1) begin
            meas.led_on <= 1'b0;
          end
          if (cnt_reg == int_cyc_reg - 24'd1) begin
            state_reg <= ST_IDLE;
            meas.integrating <= 1'b0;
            meas.led_on <= 1'b0;
            meas.done <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 24'd1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // sticky done; a finish in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b0;
    end else if (meas.done) begin
      done_reg <= 1'b1;
    end else if (done_clear) begin
      done_reg <= 1'b0;
    end
  end

endmodule : meas_cfg

// ---- verification/meas_cfg_monitor.sv ----
// concurrent checks on the measurement configuration block ports
`timescale 1ns/1ps
module meas_cfg_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire meas_cfg_pkg::meas_ctrl_t meas
);
  import meas_cfg_pkg::*;
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  a_rec_min: assert property (
    $rose(meas.recovering) |-> meas.recovering[*3]) else $error("short rec");
  // reset guard: a one-cycle reset can drop recovering without integration following
  a_rec_to_integ: assert property (
    $fell(meas.recovering) && $past(aresetn) |-> meas.integrating)
    else $error("no integration after recovery");
  a_integ_min: assert property (
    $rose(meas.integrating) |-> meas.integrating[*8])
    else $error("short integration");
  a_done_at_end: assert property (
    $fell(meas.integrating) && $past(aresetn) |-> meas.done)
    else $error("no done at end");
  a_done_pulse: assert property (meas.done |=> !meas.done)
    else $error("done too long");
  a_led_at_start: assert property (
    $rose(meas.integrating) && meas.kind == KIND_PROX && !meas.raw_mode
    |-> meas.led_on) else $error("led not on");
  a_led_gate: assert property (
    meas.led_on |-> meas.integrating && !meas.raw_mode &&
    meas.kind == KIND_PROX) else $error("led outside prox");
  a_range_prox: assert property (
    meas.high_range |-> meas.kind == KIND_PROX) else $error("range kind");
endmodule : meas_cfg_monitor

bind meas_cfg meas_cfg_monitor meas_cfg_monitor_inst (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .meas
);

// ---- verification/host_model.sv ----
// behavioural host that writes the block's configuration over axi4-lite
`timescale 1ns/1ps
module host_model (
  input wire logic aclk,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  import meas_cfg_pkg::*;
  bit allow_unsafe = 1'b0;
  bit stuck = 1'b0;
  int lag = 0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [7:0] idx, input logic [31:0] d,
                           output logic [1:0] resp);
    int n;
    n = 0;
    if (idx == IDX_PROX_GAIN && d[2:0] > 3'h5 && !allow_unsafe) d[2:0] = 3'h5;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // lag holds ready back so the slave must keep its answer standing
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n >= lag && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready) && n < 200);
    resp = s_axi_bresp;
    stuck = stuck | (s_axi_bvalid !== 1'b1) | !s_axi_bready;
    s_axi_bready <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] idx, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready) && n < 200);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    stuck = stuck | (s_axi_rvalid !== 1'b1) | !s_axi_rready;
    s_axi_rready <= 1'b0;
  endtask : reg_read

  task automatic set_visible(input logic [2:0] g);
    logic [1:0] r;
    reg_write(IDX_VIS_GAIN, {29'h0, g}, r);
    reg_write(IDX_VIS_REC, {25'h0, ~g, 4'h0}, r);
  endtask : set_visible
endmodule : host_model

// ---- verification/testbench.sv ----
// register and sequencer tests of the measurement configuration block
`timescale 1ns/1ps
module testbench;
  import meas_cfg_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  meas_cfg_pkg::meas_ctrl_t meas;
  int err_count = 0;
  int tests_run = 0;
  int rec_n, int_n, led_n;
  localparam logic [7:0] RIDX [5] = '{IDX_PROX_GAIN, IDX_PROX_MISC,
    IDX_IR_SEL, IDX_AUX_SEL, IDX_VIS_REC};
  localparam logic [7:0] RVAL [5] = '{8'h00, 8'h04, 8'h00, 8'h65, 8'h70};
  localparam logic [7:0] WIDX [5] = '{IDX_PROX_GAIN, IDX_PROX_MISC,
    IDX_VIS_REC, IDX_PROX_REC, IDX_VIS_GAIN};
  localparam logic [7:0] WEXP [5] = '{8'h07, 8'h24, 8'h70, 8'h70, 8'h07};

  meas_cfg meas_cfg_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .meas);
  host_model host_model_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // phase lengths counted where outputs are settled
  always @(negedge aclk) begin
    if (meas.recovering === 1'b1) rec_n++;
    if (meas.integrating === 1'b1) int_n++;
    if (meas.led_on === 1'b1) led_n++;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang();
    if (host_model_inst.stuck) begin
      err_count++;
      conclude();
    end
  endtask : hang
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    host_model_inst.reg_write(i, d, r);
    hang();
    chk(r, er);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] ed,
                    input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    host_model_inst.reg_read(i, q, r);
    hang();
    chk(q, ed);
    chk(r, er);
  endtask : rd
  function automatic int cyc(input int base, input int g);
    return (base * (1 << g) * ADC_CLK_NS + CLK_NS - 1) / CLK_NS;
  endfunction : cyc
  task automatic run(input int k, input int e, input int g, input int c,
                     input logic [7:0] code, input logic raw, input logic hr);
    int n;
    int le;
    n = 0;
    rec_n = 0;
    int_n = 0;
    led_n = 0;
    wr(IDX_CTRL, {27'h0, e[0], 1'b0, k[1:0], 1'b1}, AXI_OKAY);
    while (meas.done !== 1'b1 && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      conclude();
    end
    chk(rec_n, cyc(int'(REC_CLKS[c]), g));
    chk(int_n, cyc(int'(INTEG_BASE_ADC_CLKS), g));
    le = (k == 0 && !raw) ? cyc(int'(LED_BASE_ADC_CLKS), g) : 0;
    chk(led_n, le);
    chk({meas.kind, meas.input_code}, {k[1:0], code});
    chk({meas.raw_mode, meas.high_range}, {raw, hr});
  endtask : run

  initial begin
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(RIDX[i], {24'h0, RVAL[i]}, AXI_OKAY);
    end
    host_model_inst.allow_unsafe = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(WIDX[i], 32'hffff_ffff, AXI_OKAY);
      rd(WIDX[i], {24'h0, WEXP[i]}, AXI_OKAY);
    end
    wr(8'h0d, 32'h1, AXI_SLVERR);
    rd(8'h0d, 32'h0, AXI_SLVERR);
    wr(IDX_PROX_GAIN, 32'h0, AXI_OKAY);
    wr(IDX_PROX_REC, 32'h0, AXI_OKAY);
    run(0, 0, 0, 0, 8'h00, 1'b0, 1'b1);
    wr(IDX_PROX_GAIN, 32'h1, AXI_OKAY);
    wr(IDX_PROX_REC, 32'h10, AXI_OKAY);
    wr(IDX_PROX_MISC, 32'h0, AXI_OKAY);
    run(0, 0, 1, 1, 8'h00, 1'b1, 1'b0);
    wr(IDX_PROX_MISC, 32'h04, AXI_OKAY);
    host_model_inst.set_visible(3'h2);
    run(1, 0, 2, 5, 8'h00, 1'b0, 1'b0);
    wr(IDX_IR_SEL, 32'h03, AXI_OKAY);
    run(2, 0, 0, 0, 8'h03, 1'b0, 1'b0);
    // early flag must stand before the start that relies on it
    wr(IDX_CTRL, 32'h10, AXI_OKAY);
    run(2, 1, 2, 5, 8'h03, 1'b0, 1'b0);
    wr(IDX_AUX_SEL, 32'h75, AXI_OKAY);
    run(3, 0, 0, 0, 8'h75, 1'b0, 1'b0);
    rd(IDX_CTRL, 32'h06, AXI_OKAY);
    rd(IDX_STATUS, 32'h02, AXI_OKAY);
    wr(IDX_STATUS, 32'h02, AXI_OKAY);
    rd(IDX_STATUS, 32'h00, AXI_OKAY);
    // stalled response ready: answers must hold until taken
    host_model_inst.lag = 3;
    wr(IDX_VIS_GAIN, 32'h03, AXI_OKAY);
    rd(IDX_VIS_GAIN, 32'h03, AXI_OKAY);
    host_model_inst.lag = 0;
    conclude();
  end
endmodule : testbench
